/* src/gate_opt_pkg.sv */
package gate_opt_pkg;
  // Controller clock and one-second time base.
  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned TICK_TIME_S = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ * TICK_TIME_S;
  localparam int TICK_W = 24;
  localparam int SEC_W = 7;
  localparam logic [SEC_W-1:0] SEC_ZERO = 7'h00;
  localparam logic [SEC_W-1:0] SEC_ONE = 7'h01;

  // Timing settings in seconds.
  localparam logic [3:0] REV_DELAY_DEFAULT_S = 4'h1;
  localparam logic [3:0] REV_DELAY_MAX_S = 4'h9;
  localparam logic [3:0] SOFT_RAMP_DEFAULT_S = 4'h3;
  localparam logic [3:0] SOFT_RAMP_MAX_S = 4'ha;
  localparam logic [SEC_W-1:0] LOW_POWER_IDLE_S = 7'h3c;
  localparam logic [SEC_W-1:0] POWER_FAIL_WAIT_S = 7'h05;
  localparam logic [SEC_W-1:0] MID_STOP_MAX_S = 7'h63;
  localparam logic [SEC_W-1:0] CLEAR_HOLD_S = 7'h02;

  // Cycle counters.
  localparam int CNT_W = 24;
  localparam logic [CNT_W-1:0] CNT_ZERO = 24'h000000;
  localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;
  localparam logic [CNT_W-1:0] SERVICE_5K = 24'h001388;
  localparam logic [CNT_W-1:0] SERVICE_10K = 24'h002710;
  localparam logic [CNT_W-1:0] SERVICE_15K = 24'h003a98;
  localparam logic [CNT_W-1:0] SERVICE_25K = 24'h0061a8;
  localparam int CUR_W = 7;
  localparam logic [CUR_W-1:0] CUR_ZERO = 7'h00;

  typedef enum logic [1:0] {
    SERVICE_SEL_5K = 2'h0,
    SERVICE_SEL_10K = 2'h1,
    SERVICE_SEL_15K = 2'h2,
    SERVICE_SEL_25K = 2'h3
  } service_sel_type;

  typedef enum logic [1:0] {
    PFAIL_SAFE = 2'h0,
    PFAIL_SECURE = 2'h1,
    PFAIL_OPEN_NOW = 2'h2,
    PFAIL_CLOSE_NOW = 2'h3
  } pfail_type;

  typedef enum logic [2:0] {
    MOTOR_AC = 3'h0,
    MOTOR_DC_BRAKE = 3'h1,
    MOTOR_DC_SOFT = 3'h2,
    MOTOR_AC_3PH = 3'h3,
    MOTOR_AC_DC_BRAKE = 3'h4,
    MOTOR_AC_DC_SOFT = 3'h5
  } motor_type;

  // Gray-coded motion states along idle, opening, reverse wait, closing, paused, halted.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_OPENING = 3'b001,
    ST_REV_WAIT = 3'b011,
    ST_CLOSING = 3'b010,
    ST_PAUSED = 3'b110,
    ST_HALTED = 3'b111
  } motion_type;

  typedef struct packed {
    logic [3:0] rev_delay_s;
    logic [1:0] constant_press;
    logic shadow_open_block;
    logic low_power_en;
    pfail_type pfail_policy;
    logic [3:0] soft_ramp_s;
    service_sel_type service_sel;
    logic [SEC_W-1:0] mid_stop_s;
    logic anti_tailgate;
    logic stagger_en;
    logic dual_gate_en;
    logic open_loop_wake;
    motor_type motor_sel;
  } config_type;

  typedef struct packed {
    logic open_btn;
    logic close_btn;
    logic stop_btn;
    logic open_loop;
    logic reverse_loop;
    logic shadow_loop;
    logic open_obstruct;
    logic close_obstruct;
    logic entrapment;
    logic fire_dept;
    logic radio;
    logic auto_close;
    logic enter_btn;
    logic count_shown;
    logic service_clear;
  } inputs_type;

  typedef struct packed {
    logic open_limit;
    logic close_limit;
    logic ac_present;
    logic battery_low;
  } sense_type;

  typedef struct packed {
    logic motor_open;
    logic motor_close;
    logic soft_ramp;
    logic low_power;
    logic accessory_on;
    logic indicators_on;
    logic service_due_indicator;
  } drive_type;
endpackage

/* src/gate_motion_option_control.sv */
`timescale 1ns/100ps
// How it works
// - Reversal waits the set delay, one second by default, nine at most.
// - Obstruction or entrapment reversals skip the reverse delay.
// - Buttons start a full cycle unless set for continuous pressure.
// - Releasing a held constant-pressure button before the limit stops the gate.
// - At full open with shadow loop active, closing requests are blocked.
// - Optional setting blocks opening at close limit while shadow loop active.
// - Enabled, AC absent, idle sixty seconds: low power, accessories and lights off.
// - Only radio, reverse loop, open loop if enabled, fire, AC wake it.
// - Fail safe: AC lost and battery low opens after five seconds.
// - Fail secure: AC lost and battery low closes after five seconds.
// - Stagger mode inhibits fail safe and fail secure.
// - Immediate policies drive open or closed on AC loss, then halt.
// - Soft ramp only on starts from idle: any opening, closing only from full open; 3 s default.
// - Changing ramp duration clears both stored maximum current settings.
// - Count full cycles; hold enter two seconds while shown to clear.
// - Clearing the cycle count clears the service indicator only if the service count is not past its limit.
// - Service indicator lights past 5, 10, 15 or 25 thousand cycles.
// - Service counter clears separately from the absolute count.
// - Mid-travel stop ends an opening after the set run time.
// - Fire, held open button, close obstruction or reverse loop open fully.
// - Dual gate operation inhibits mid-travel stop.
// - Anti-tailgate closes when shadow clears; new trigger pauses closing.
module gate_motion_option_control
  import gate_opt_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Settings and control stations
  input wire gate_opt_pkg::config_type cfg,
  input wire gate_opt_pkg::inputs_type in,
  input wire gate_opt_pkg::sense_type sense,
  // Current settings load
  input wire logic cur_load,
  input wire logic [gate_opt_pkg::CUR_W-1:0] cur_open_in,
  input wire logic [gate_opt_pkg::CUR_W-1:0] cur_close_in,
  // Drive and status
  output gate_opt_pkg::drive_type drive,
  output gate_opt_pkg::motion_type motion,
  output logic [gate_opt_pkg::CNT_W-1:0] cycle_count,
  output logic [gate_opt_pkg::CNT_W-1:0] service_count,
  output logic [gate_opt_pkg::CUR_W-1:0] cur_open_max,
  output logic [gate_opt_pkg::CUR_W-1:0] cur_close_max
);
  import gate_opt_pkg::*;

  typedef struct packed {
    logic [TICK_W-1:0] tick_cnt;
    motion_type st;
    logic dir_open;
    logic pend_open;
    logic [SEC_W-1:0] run_s;
    logic [SEC_W-1:0] wait_s;
    logic [SEC_W-1:0] idle_s;
    logic [SEC_W-1:0] pfail_s;
    logic [SEC_W-1:0] enter_s;
    logic full_open;
    logic held;
    logic opened;
    logic shadow_seen;
    logic shadow_prev;
    logic pfail_done;
    logic [3:0] ramp_prev;
    logic [SEC_W-1:0] ramp_s;
    drive_type drv;
    logic [CNT_W-1:0] cycles;
    logic [CNT_W-1:0] service;
    logic [CUR_W-1:0] cur_open;
    logic [CUR_W-1:0] cur_close;
  } state_type;

  state_type s_q;
  state_type s_d;

  function automatic logic [CNT_W-1:0] service_limit(input service_sel_type sel);
    case (sel)
      SERVICE_SEL_5K: service_limit = SERVICE_5K;
      SERVICE_SEL_15K: service_limit = SERVICE_15K;
      SERVICE_SEL_25K: service_limit = SERVICE_25K;
      default: service_limit = SERVICE_10K;
    endcase
  endfunction

  function automatic logic [SEC_W-1:0] sec_bump(input logic [SEC_W-1:0] v, input logic t);
    sec_bump = (t && v != MID_STOP_MAX_S) ? v + SEC_ONE : v;
  endfunction

  logic tick;
  logic open_req;
  logic close_req;
  logic wake;
  logic obstruct_rev;
  logic full_force;
  logic pfail_trig;
  logic [3:0] rev_s;
  logic [3:0] ramp_set;
  logic mid_active;
  logic moving;
  logic ac_halt;

  always_comb begin
    tick = (s_q.tick_cnt == TICK_W'(TICK_DIV - 1));
    rev_s = (cfg.rev_delay_s > REV_DELAY_MAX_S) ? REV_DELAY_MAX_S : cfg.rev_delay_s;
    if (cfg.rev_delay_s == 4'h0) begin
      rev_s = REV_DELAY_DEFAULT_S;
    end
    ramp_set = (cfg.soft_ramp_s > SOFT_RAMP_MAX_S) ? SOFT_RAMP_MAX_S : cfg.soft_ramp_s;
    moving = (s_q.st == ST_OPENING) || (s_q.st == ST_CLOSING);
    // Immediate policies halt gate motion on AC loss once the target limit is reached; counters, clears and low power keep running.
    ac_halt = !sense.ac_present && (cfg.pfail_policy == PFAIL_OPEN_NOW ||
      cfg.pfail_policy == PFAIL_CLOSE_NOW);
    obstruct_rev = (s_q.st == ST_CLOSING) && (in.close_obstruct || in.entrapment);
    full_force = in.fire_dept || in.close_obstruct || in.reverse_loop;
    open_req = in.open_btn || in.open_loop || in.fire_dept || in.radio ||
      in.reverse_loop && (s_q.st == ST_CLOSING);
    if (sense.close_limit && in.shadow_loop && cfg.shadow_open_block && !in.fire_dept) begin
      open_req = 1'b0;
    end
    close_req = in.close_btn || in.auto_close;
    if (sense.open_limit && in.shadow_loop) begin
      close_req = 1'b0;
    end
    if (cfg.anti_tailgate && s_q.shadow_prev && !in.shadow_loop && s_q.opened) begin
      close_req = 1'b1;
    end
    wake = in.radio || in.reverse_loop || (in.open_loop && cfg.open_loop_wake) ||
      in.fire_dept || sense.ac_present;
    mid_active = (cfg.mid_stop_s != SEC_ZERO) && !cfg.dual_gate_en && !s_q.full_open;
    pfail_trig = !sense.ac_present && sense.battery_low && !cfg.stagger_en &&
      (s_q.pfail_s == POWER_FAIL_WAIT_S) && !s_q.pfail_done;
  end

  always_comb begin
    s_d = s_q;
    s_d.tick_cnt = tick ? '0 : s_q.tick_cnt + TICK_W'(1);
    s_d.shadow_prev = in.shadow_loop;
    s_d.run_s = sec_bump(s_q.run_s, tick);
    s_d.wait_s = sec_bump(s_q.wait_s, tick);
    s_d.idle_s = moving ? SEC_ZERO : sec_bump(s_q.idle_s, tick);
    s_d.ramp_s = sec_bump(s_q.ramp_s, tick);

    // Low-battery wait restarts each time the condition lapses.
    if (sense.ac_present || !sense.battery_low) begin
      s_d.pfail_s = SEC_ZERO;
      s_d.pfail_done = 1'b0;
    end else begin
      s_d.pfail_s = sec_bump(s_q.pfail_s, tick);
    end

    case (s_q.st)
      ST_IDLE: begin
        s_d.held = in.open_btn || in.close_btn;
        if (pfail_trig) begin
          s_d.pfail_done = 1'b1;
          if (cfg.pfail_policy == PFAIL_SAFE && !sense.open_limit) begin
            s_d.st = ST_OPENING;
            s_d.dir_open = 1'b1;
          end else if (cfg.pfail_policy == PFAIL_SECURE && !sense.close_limit) begin
            s_d.st = ST_CLOSING;
            s_d.dir_open = 1'b0;
          end
        end else if (ac_halt) begin
          s_d.held = 1'b0;
          if (cfg.pfail_policy == PFAIL_OPEN_NOW && !sense.open_limit) begin
            s_d.st = ST_OPENING;
            s_d.dir_open = 1'b1;
          end else if (cfg.pfail_policy == PFAIL_CLOSE_NOW && !sense.close_limit) begin
            s_d.st = ST_CLOSING;
            s_d.dir_open = 1'b0;
          end else begin
            s_d.st = ST_HALTED;
          end
        end else if (open_req && !sense.open_limit) begin
          s_d.st = ST_OPENING;
          s_d.dir_open = 1'b1;
        end else if (close_req && !sense.close_limit) begin
          s_d.st = ST_CLOSING;
          s_d.dir_open = 1'b0;
        end
        if (s_d.st != ST_IDLE) begin
          s_d.run_s = SEC_ZERO;
          s_d.ramp_s = SEC_ZERO;
          s_d.full_open = full_force;
          s_d.opened = 1'b0;
        end
      end
      ST_OPENING: begin
        if (in.open_btn && mid_active && s_q.run_s == cfg.mid_stop_s) begin
          s_d.full_open = 1'b1;
        end
        if (full_force) begin
          s_d.full_open = 1'b1;
        end
        if (in.stop_btn || in.open_obstruct) begin
          s_d.st = ST_IDLE;
        end else if (cfg.constant_press[0] && s_q.held && !in.open_btn) begin
          s_d.st = ST_IDLE;
        end else if (sense.open_limit) begin
          s_d.st = ST_IDLE;
          s_d.opened = 1'b1;
        end else if (mid_active && !in.open_btn && s_q.run_s >= cfg.mid_stop_s) begin
          s_d.st = ST_IDLE;
        end else if (in.close_btn) begin
          s_d.st = ST_REV_WAIT;
          s_d.pend_open = 1'b0;
          s_d.wait_s = SEC_ZERO;
        end
      end
      ST_CLOSING: begin
        if (in.stop_btn) begin
          s_d.st = ST_IDLE;
        end else if (obstruct_rev) begin
          s_d.st = ST_OPENING;
          s_d.dir_open = 1'b1;
          s_d.full_open = 1'b1;
          s_d.run_s = SEC_ZERO;
        end else if (cfg.constant_press[1] && s_q.held && !in.close_btn) begin
          s_d.st = ST_IDLE;
        end else if (sense.close_limit) begin
          s_d.st = ST_IDLE;
          if (s_q.opened) begin
            s_d.cycles = s_q.cycles + CNT_ONE;
            s_d.service = s_q.service + CNT_ONE;
          end
        end else if (cfg.anti_tailgate && in.shadow_loop) begin
          s_d.st = ST_PAUSED;
        end else if (open_req) begin
          s_d.st = ST_REV_WAIT;
          s_d.pend_open = 1'b1;
          s_d.wait_s = SEC_ZERO;
          s_d.full_open = full_force;
        end
      end
      ST_REV_WAIT: begin
        if (in.stop_btn) begin
          s_d.st = ST_IDLE;
        end else if (s_q.wait_s >= {3'h0, rev_s}) begin
          s_d.st = s_q.pend_open ? ST_OPENING : ST_CLOSING;
          s_d.dir_open = s_q.pend_open;
          s_d.run_s = SEC_ZERO;
        end
      end
      ST_PAUSED: begin
        if (in.stop_btn) begin
          s_d.st = ST_IDLE;
        end else if (!in.shadow_loop) begin
          s_d.st = ST_CLOSING;
        end
      end
      ST_HALTED: begin
        if (sense.ac_present) begin
          s_d.st = ST_IDLE;
        end
      end
      default: s_d.st = ST_IDLE;
    endcase
    if (s_q.st == ST_IDLE && sense.open_limit && !moving) begin
      s_d.opened = 1'b1;
    end
    if (s_q.st == ST_IDLE && s_d.st == ST_IDLE && ac_halt) begin
      s_d.st = ST_HALTED;
    end

    // Enter held for two seconds while the count is shown clears it.
    s_d.enter_s = (in.enter_btn && in.count_shown) ? sec_bump(s_q.enter_s, tick) : SEC_ZERO;
    if (s_q.enter_s == CLEAR_HOLD_S && in.enter_btn && in.count_shown) begin
      s_d.cycles = CNT_ZERO;
      s_d.service = CNT_ZERO;
      s_d.drv.service_due_indicator = 1'b0;
      s_d.enter_s = SEC_ZERO;
    end
    if (in.service_clear) begin
      s_d.service = CNT_ZERO;
    end
    if (s_q.service > service_limit(cfg.service_sel)) begin
      s_d.drv.service_due_indicator = 1'b1;
    end

    // Stored current settings; a ramp change clears both and wins over a load.
    s_d.ramp_prev = ramp_set;
    if (cur_load) begin
      s_d.cur_open = cur_open_in;
      s_d.cur_close = cur_close_in;
    end
    if (ramp_set != s_q.ramp_prev) begin
      s_d.cur_open = CUR_ZERO;
      s_d.cur_close = CUR_ZERO;
    end

    s_d.drv.motor_open = (s_d.st == ST_OPENING);
    s_d.drv.motor_close = (s_d.st == ST_CLOSING);
    // Ramp only on starts from idle (closing only from full open), and only on a soft-start motor.
    s_d.drv.soft_ramp = (cfg.motor_sel == MOTOR_DC_SOFT || cfg.motor_sel == MOTOR_AC_DC_SOFT) &&
      moving && (s_q.ramp_s < {3'h0, ramp_set}) &&
      (s_q.dir_open ? s_q.opened == 1'b0 : s_q.opened);

    if (cfg.low_power_en && !sense.ac_present && s_q.idle_s >= LOW_POWER_IDLE_S) begin
      s_d.drv.low_power = 1'b1;
    end
    if (s_q.drv.low_power && wake) begin
      s_d.drv.low_power = 1'b0;
      s_d.idle_s = SEC_ZERO;
    end
    s_d.drv.accessory_on = !s_d.drv.low_power;
    s_d.drv.indicators_on = !s_d.drv.low_power;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_q <= '0;
      s_q.ramp_prev <= SOFT_RAMP_DEFAULT_S;
      s_q.drv.accessory_on <= 1'b1;
      s_q.drv.indicators_on <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign drive = s_q.drv;
  assign motion = s_q.st;
  assign cycle_count = s_q.cycles;
  assign service_count = s_q.service;
  assign cur_open_max = s_q.cur_open;
  assign cur_close_max = s_q.cur_close;
endmodule

/* verification/gate_plant.sv */
`timescale 1ns/100ps
module gate_plant
  import gate_opt_pkg::*;
#(
  parameter int TRAVEL = 60
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Motor drive and limit switches
  input wire gate_opt_pkg::drive_type drive,
  output logic open_limit,
  output logic close_limit
);
  int pos;

  // The gate moves one step per clock, so a full run takes TRAVEL cycles.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pos <= 0;
    end else if (drive.motor_open && pos < TRAVEL) begin
      pos <= pos + 1;
    end else if (drive.motor_close && pos > 0) begin
      pos <= pos - 1;
    end
  end
  assign open_limit = (pos == TRAVEL);
  assign close_limit = (pos == 0);
endmodule

/* verification/gate_option_checker.sv */
`timescale 1ns/100ps
module gate_option_checker
  import gate_opt_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Settings, stations and sensing
  input wire gate_opt_pkg::config_type cfg,
  input wire gate_opt_pkg::inputs_type in,
  input wire gate_opt_pkg::sense_type sense,
  input wire logic cur_load,
  input wire logic [gate_opt_pkg::CUR_W-1:0] cur_open_in,
  input wire logic [gate_opt_pkg::CUR_W-1:0] cur_close_in,
  // Drive and status
  input wire gate_opt_pkg::drive_type drive,
  input wire gate_opt_pkg::motion_type motion,
  input wire logic [gate_opt_pkg::CNT_W-1:0] cycle_count,
  input wire logic [gate_opt_pkg::CNT_W-1:0] service_count,
  input wire logic [gate_opt_pkg::CUR_W-1:0] cur_open_max,
  input wire logic [gate_opt_pkg::CUR_W-1:0] cur_close_max
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  a_wait_still: assert property (
    motion == ST_REV_WAIT |-> !drive.motor_open && !drive.motor_close)
    else $error("motor driven during reverse wait");
  a_obstruct_reverse: assert property (
    motion == ST_CLOSING && in.close_obstruct && !in.stop_btn && !sense.close_limit
    |=> motion == ST_OPENING) else $error("obstruction reversal was delayed");
  a_hold_release: assert property (
    cfg.constant_press[0] && drive.motor_open && motion == ST_OPENING && !in.open_btn
    && !sense.open_limit && sense.ac_present && !in.fire_dept && !in.reverse_loop
    && !in.close_obstruct |=> !drive.motor_open) else $error("released open kept running");
  a_shadow_close: assert property (
    sense.open_limit && in.shadow_loop && sense.ac_present && !drive.motor_close
    |=> !drive.motor_close) else $error("closed over active shadow loop");
  a_shadow_open: assert property (
    cfg.shadow_open_block && sense.close_limit && in.shadow_loop && sense.ac_present
    && !in.fire_dept && !drive.motor_open |=> !drive.motor_open)
    else $error("opened over active shadow loop");
  a_low_power_dark: assert property (
    drive.low_power |-> !drive.accessory_on && !drive.indicators_on)
    else $error("accessories lit in low power");
  a_ac_wakes: assert property (
    sense.ac_present [*2] |-> !drive.low_power) else $error("low power with AC present");
  a_halt_still: assert property (
    motion == ST_HALTED |-> !drive.motor_open && !drive.motor_close)
    else $error("motor driven while halted");
  a_ramp_clears: assert property (
    cfg.soft_ramp_s != $past(cfg.soft_ramp_s) && !cur_load
    |-> ##[1:2] (cur_open_max == CUR_ZERO && cur_close_max == CUR_ZERO))
    else $error("current settings kept after ramp change");
  a_service_clear: assert property (
    in.service_clear |=> service_count == CNT_ZERO) else $error("service count not cleared");
  a_count_kept: assert property (
    in.service_clear && !in.enter_btn && motion != ST_CLOSING |=> $stable(cycle_count))
    else $error("service clear touched cycle count");
  a_service_quiet: assert property (
    service_count <= SERVICE_5K && $past(service_count) <= SERVICE_5K
    |-> !drive.service_due_indicator) else $error("service indicator below threshold");

  c_rev_wait: cover property (motion == ST_REV_WAIT);
  c_paused: cover property (motion == ST_PAUSED);
  c_low_power: cover property (drive.low_power);
  c_halted: cover property (motion == ST_HALTED);
endmodule

bind gate_motion_option_control gate_option_checker chk (.clk, .reset, .cfg, .in, .sense,
  .cur_load, .cur_open_in, .cur_close_in, .drive, .motion, .cycle_count, .service_count,
  .cur_open_max, .cur_close_max);

/* verification/gate_motion_option_control_test.sv */
`timescale 1ns/100ps
module gate_motion_option_control_test;
  import gate_opt_pkg::*;
  // One second lasts T clocks here so that the run stays short.
  localparam int T = 10;
  localparam int B_OPEN = 14, B_CLOSE = 13, B_STOP = 12, B_SHADOW = 9, B_OBST = 7;
  localparam int B_RADIO = 4, B_ENTER = 2, B_SHOWN = 1, B_SCLR = 0;
  logic clk, reset, cur_load, ac, batt, open_lim, close_lim;
  config_type cfg;
  inputs_type in;
  sense_type sense;
  logic [CUR_W-1:0] cur_in;
  drive_type drive;
  motion_type motion;
  logic [CNT_W-1:0] cycle_count, service_count;
  logic [CUR_W-1:0] cur_open_max, cur_close_max;
  int bad_count = 0, n_tests = 0, cyc = 0, n;

  assign sense = '{open_lim, close_lim, ac, batt};
  gate_motion_option_control #(.TICK_DIV(T)) DUT (.clk(clk), .reset(reset), .cfg(cfg),
    .in(in), .sense(sense), .cur_load(cur_load), .cur_open_in(cur_in), .cur_close_in(~cur_in),
    .drive(drive), .motion(motion), .cycle_count(cycle_count), .service_count(service_count),
    .cur_open_max(cur_open_max), .cur_close_max(cur_close_max));
  gate_plant plant (.clk(clk), .reset(reset), .drive(drive), .open_limit(open_lim),
    .close_limit(close_lim));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task print_verdict;
    $display("mismatches %0d, comparisons %0d", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task report(input logic [CNT_W-1:0] a, input logic [CNT_W-1:0] e);
    n_tests++;
    if (a !== e) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, a, e);
    end
  endtask
  task check_bit(input logic a, input logic e);
    report({23'h0, a}, {23'h0, e});
  endtask
  task check_cnt(input logic [CNT_W-1:0] a, input logic [CNT_W-1:0] e);
    report(a, e);
  endtask
  task check_st(input motion_type a, input motion_type e);
    report({21'h0, a}, {21'h0, e});
  endtask

  task step(input int k);
    repeat (k) @(negedge clk);
  endtask
  task press(input int b);
    in[b] = 1'b1;
    step(1);
    in[b] = 1'b0;
  endtask
  // A limit that is never reached is reported and the run goes on.
  task wait_lim(input bit op);
    int k;
    for (k = 0; k < 300 && (op ? open_lim : close_lim) !== 1'b1; k++) step(1);
    check_bit(op ? open_lim : close_lim, 1'b1);
    // The state machine sees the limit only at the next edge, so a press made now would be lost.
    step(2);
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      print_verdict();
    end
  end

  initial begin
    cfg = '{4'h1, 2'h0, 1'b0, 1'b0, PFAIL_SAFE, 4'h3, SERVICE_SEL_10K, 7'h00, 1'b0, 1'b0, 1'b0,
      1'b0, MOTOR_DC_SOFT};
    in = '0;
    {ac, batt, cur_load, cur_in, reset} = {1'b1, 1'b0, 1'b0, 7'h21, 1'b1};
    step(3);
    check_bit(drive.accessory_on, 1'b1);
    check_st(motion, ST_IDLE);
    step(1);
    reset = 1'b0;
    press(B_OPEN);
    check_bit(drive.motor_open, 1'b1);
    step(5);
    check_bit(drive.motor_open, 1'b1);
    check_bit(drive.soft_ramp, 1'b1);
    step(3 * T + 2);
    check_bit(drive.soft_ramp, 1'b0);
    wait_lim(1);
    step(2);
    check_bit(drive.motor_open, 1'b0);
    press(B_CLOSE);
    wait_lim(0);
    step(2);
    check_cnt(cycle_count, CNT_ONE);
    cur_load = 1'b1;
    step(1);
    cur_load = 1'b0;
    check_cnt({17'h0, cur_close_max}, 24'h00005e);
    cfg.soft_ramp_s = 4'h5;
    step(3);
    check_cnt({17'h0, cur_open_max, cur_close_max}, CNT_ZERO);
    cfg.rev_delay_s = 4'h3;
    press(B_OPEN);
    step(T);
    press(B_CLOSE);
    check_st(motion, ST_REV_WAIT);
    for (n = 0; n < 100 && motion !== ST_CLOSING; n++) step(1);
    check_bit(n >= 2 * T && n <= 3 * T + 2, 1'b1);
    wait_lim(0);
    step(2);
    check_cnt(cycle_count, CNT_ONE);
    press(B_OPEN);
    wait_lim(1);
    press(B_CLOSE);
    step(T);
    press(B_OBST);
    check_st(motion, ST_OPENING);
    wait_lim(1);
    in[B_SHADOW] = 1'b1;
    press(B_CLOSE);
    step(5);
    check_bit(drive.motor_close, 1'b0);
    cfg.anti_tailgate = 1'b1;
    in[B_SHADOW] = 1'b0;
    step(3);
    check_bit(drive.motor_close, 1'b1);
    in[B_SHADOW] = 1'b1;
    step(2);
    check_st(motion, ST_PAUSED);
    in[B_SHADOW] = 1'b0;
    step(3);
    check_bit(drive.motor_close, 1'b1);
    wait_lim(0);
    cfg.anti_tailgate = 1'b0;
    cfg.shadow_open_block = 1'b1;
    in[B_SHADOW] = 1'b1;
    press(B_OPEN);
    step(3);
    check_bit(drive.motor_open, 1'b0);
    {in[B_SHADOW], cfg.shadow_open_block, cfg.constant_press} = 4'h1;
    in[B_OPEN] = 1'b1;
    step(T);
    in[B_OPEN] = 1'b0;
    step(2);
    check_bit(drive.motor_open, 1'b0);
    cfg.constant_press = 2'h0;
    press(B_CLOSE);
    wait_lim(0);
    cfg.mid_stop_s = 7'h02;
    press(B_OPEN);
    step(35);
    check_bit(drive.motor_open | open_lim, 1'b0);
    press(B_CLOSE);
    wait_lim(0);
    cfg.dual_gate_en = 1'b1;
    press(B_OPEN);
    wait_lim(1);
    press(B_CLOSE);
    wait_lim(0);
    step(2);
    check_cnt(cycle_count, 24'h000003);
    press(B_SCLR);
    check_cnt(service_count, CNT_ZERO);
    check_cnt(cycle_count, 24'h000003);
    {in[B_ENTER], in[B_SHOWN]} = 2'h3;
    step(5);
    {in[B_ENTER], in[B_SHOWN]} = 2'h0;
    step(1);
    check_cnt(cycle_count, 24'h000003);
    {in[B_ENTER], in[B_SHOWN]} = 2'h3;
    step(3 * T + 2);
    {in[B_ENTER], in[B_SHOWN]} = 2'h0;
    check_cnt(cycle_count, CNT_ZERO);
    {ac, batt} = 2'h1;
    step(3 * T + 5);
    check_bit(drive.motor_open, 1'b0);
    step(25);
    check_bit(drive.motor_open, 1'b1);
    {ac, batt} = 2'h2;
    wait_lim(1);
    press(B_CLOSE);
    wait_lim(0);
    cfg.low_power_en = 1'b1;
    ac = 1'b0;
    step(62 * T);
    check_bit(drive.low_power, 1'b1);
    check_bit(drive.accessory_on, 1'b0);
    check_bit(drive.indicators_on, 1'b0);
    press(B_STOP);
    step(2);
    check_bit(drive.low_power, 1'b1);
    press(B_RADIO);
    step(2);
    check_bit(drive.low_power, 1'b0);
    {ac, cfg.low_power_en} = 2'h2;
    press(B_OPEN);
    wait_lim(1);
    cfg.pfail_policy = PFAIL_CLOSE_NOW;
    ac = 1'b0;
    wait_lim(0);
    step(3);
    check_st(motion, ST_HALTED);
    press(B_OPEN);
    step(3);
    check_bit(drive.motor_open, 1'b0);
    print_verdict();
  end
endmodule
